/* File: common/spc_pkg.sv */
// Purpose: Shared constants and types of the serial port block
// Assumes: Register bus with byte addresses, one 32-bit word per register
// Notes: Control registers are 16 bits wide and sit in the low lanes
package spc_pkg;

  // Register byte offsets
  localparam logic [3:0] OFS_CONTROL_ONE = 4'h0;
  localparam logic [3:0] OFS_CONTROL_TWO = 4'h4;
  localparam logic [3:0] OFS_DATA = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hc;

  // Implemented bits and reset values
  localparam logic [15:0] CONTROL_ONE_MASK = 16'h1fff;
  localparam logic [15:0] CONTROL_TWO_MASK = 16'he002;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;

  // Status bit positions
  localparam int ST_ENABLE = 15;
  localparam int ST_OVERFLOW = 6;
  localparam int ST_BUSY = 2;
  localparam int ST_TX_FULL = 1;
  localparam int ST_RX_FULL = 0;

  // Word sizes and top bit indices
  localparam logic [4:0] BITS_BYTE = 5'h08;
  localparam logic [4:0] BITS_WORD = 5'h10;
  localparam logic [3:0] TOP_BYTE = 4'h7;
  localparam logic [3:0] TOP_WORD = 4'hf;

  // Prescaler code bases
  localparam logic [3:0] SECONDARY_STEPS = 4'h8;
  localparam logic [1:0] PRIMARY_TOP = 2'h3;

  // First control register layout
  typedef struct packed {
    logic [2:0] unusedHigh;
    logic clockPinDisable;
    logic dataOutPinDisable;
    logic wordSizeSelect;
    logic inputSamplePhase;
    logic clockEdgeSelect;
    logic slaveSelectEnable;
    logic clockIdlePolarity;
    logic masterEnable;
    logic [2:0] secondaryDivider;
    logic [1:0] primaryDivider;
  } spc_ctrl_one_type;

  // Second control register layout
  typedef struct packed {
    logic framedEnable;
    logic frameSyncDirection;
    logic frameSyncPolarity;
    logic [10:0] unusedMid;
    logic frameSyncEdge;
    logic unusedLow;
  } spc_ctrl_two_type;

  // Pins seen from the block
  typedef struct packed {
    logic clockIn;
    logic dataIn;
    logic selectIn;
  } spc_pin_in_type;

  typedef struct packed {
    logic clockOut;
    logic clockOe;
    logic dataOut;
    logic dataOe;
    logic selectOut;
    logic selectOe;
  } spc_pin_out_type;

  // Transfer sequencer states
  typedef enum logic [2:0] {
    IDLE = 3'b001,
    PRESYNC = 3'b010,
    SHIFT = 3'b100
  } spc_state_type;

endpackage

/* File: hw/spc_port.sv */
// Purpose: Synchronous serial port with configurable clocking and framing
// Assumes: Avalon-MM slave, clock 250 MHz, synchronous active-high reset
// Notes: One 16-bit shift register, separate transmit and receive buffers
//
// What this block does
// - Master: clock pin disable releases the clock pin to general I/O.
// - Data-out disable releases the serial output pin; clear lets port drive it.
// - Word size select chooses 16-bit words when set, 8-bit when clear.
// - Master samples input at bit end when phase set, mid-bit when clear.
// - Edge select: output changes active-to-idle when set, idle-to-active when clear.
// - Slave with select enable uses low-active select pin; otherwise ignores it.
// - Polarity set: clock idles high; clear: clock idles low.
// - Master enable selects master operation; clear selects slave.
// - Secondary divider code 111 divides by one, down to eight at 000.
// - Primary divider codes 11,10,01,00 divide by 1,4,16,64.
// - Framed operation ignores edge select; software programs it zero.
// - Framed operation turns the select pin into frame sync pulse.
// - Frame sync direction set receives pulse, clear generates it.
// - Frame sync polarity set means active-high, clear active-low.
// - Frame edge set: pulse with first bit; clear: one bit before.
// - Unimplemented control bits read zero; control bits reset to zero.
// - Clock pin is output in master operation, input in slave.
// - Data shifts through a 16-bit register apart from the buffers.
`timescale 1ns/1ps
module spc_port (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Avalon-MM register slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output wire logic waitrequest,
  // Serial port pins
  input wire spc_pkg::spc_pin_in_type pinIn,
  output spc_pkg::spc_pin_out_type pinOut
);

  spc_pkg::spc_ctrl_one_type ctrlOne;
  spc_pkg::spc_ctrl_two_type ctrlTwo;
  spc_pkg::spc_state_type state;
  spc_pkg::spc_state_type next_state;
  logic respond;
  logic portEnable;
  logic txFull;
  logic rxFull;
  logic overflow;
  logic [15:0] txBuf;
  logic [15:0] rxBuf;
  logic [15:0] shiftReg;
  logic [9:0] divCnt;
  logic [4:0] bitCnt;
  logic outBit;
  logic sckLevel;
  logic selLevel;
  logic sckPrev;
  logic sckSync;
  logic sdiSync;
  logic selSync;

  // Overall divide ratio from both prescaler codes
  function automatic logic [9:0] divRatio(input logic [1:0] pri, input logic [2:0] sec);
    logic [9:0] priRatio;
    logic [9:0] secRatio;
    priRatio = 10'h001 << {spc_pkg::PRIMARY_TOP - pri, 1'b0};
    secRatio = {6'h00, spc_pkg::SECONDARY_STEPS - {1'b0, sec}};
    divRatio = 10'(priRatio * secRatio);
  endfunction

  // Byte lane merge for 16-bit registers
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] mask);
    logic [15:0] lanes;
    lanes = {{8{byteenable[1]}}, {8{byteenable[0]}}};
    merge = ((old & ~lanes) | (writedata[15:0] & lanes)) & mask;
  endfunction

  // Pin synchronisers
  spc_sync #(.INIT(1'b0)) syncClock (.clock(clock), .reset(reset), .async(pinIn.clockIn), .level(sckSync));
  spc_sync #(.INIT(1'b0)) syncData (.clock(clock), .reset(reset), .async(pinIn.dataIn), .level(sdiSync));
  spc_sync #(.INIT(1'b1)) syncSelect (.clock(clock), .reset(reset), .async(pinIn.selectIn), .level(selSync));

  // Bus handshake and address decode
  assign waitrequest = (read | write) & ~respond;
  wire wrAcc = write & respond;
  wire rdAcc = read & respond;
  wire hitOne = address == spc_pkg::OFS_CONTROL_ONE;
  wire hitTwo = address == spc_pkg::OFS_CONTROL_TWO;
  wire hitData = address == spc_pkg::OFS_DATA;
  wire hitStat = address == spc_pkg::OFS_STATUS;
  wire dataWr = wrAcc & hitData;
  wire dataRd = rdAcc & hitData;
  wire statWr = wrAcc & hitStat;
  wire [15:0] statusWord = (16'(portEnable) << spc_pkg::ST_ENABLE) | (16'(overflow) << spc_pkg::ST_OVERFLOW)
    | (16'(state != spc_pkg::IDLE) << spc_pkg::ST_BUSY) | (16'(txFull) << spc_pkg::ST_TX_FULL)
    | (16'(rxFull) << spc_pkg::ST_RX_FULL);
  wire [15:0] readMux = hitOne ? 16'(ctrlOne) : hitTwo ? 16'(ctrlTwo) : hitData ? rxBuf
    : hitStat ? statusWord : 16'h0000;

  // Mode decode
  wire isMaster = ctrlOne.masterEnable;
  wire framed = ctrlTwo.framedEnable;
  wire frameMaster = framed & ~ctrlTwo.frameSyncDirection;
  wire ckeEff = ctrlOne.clockEdgeSelect & ~framed;
  wire smpEff = ctrlOne.inputSamplePhase & isMaster;
  wire wide = ctrlOne.wordSizeSelect;
  wire [4:0] wordBits = wide ? spc_pkg::BITS_WORD : spc_pkg::BITS_BYTE;
  wire [3:0] topIdx = wide ? spc_pkg::TOP_WORD : spc_pkg::TOP_BYTE;
  wire [3:0] nextTop = topIdx - 4'h1;
  wire [9:0] ratio = divRatio(ctrlOne.primaryDivider, ctrlOne.secondaryDivider);
  wire [9:0] halfRatio = {1'b0, ratio[9:1]};
  wire syncActive = selSync == ctrlTwo.frameSyncPolarity;
  wire slaveSelected = framed ? syncActive : (ctrlOne.slaveSelectEnable ? ~selSync : 1'b1);
  wire inWord = state == spc_pkg::SHIFT;

  // Bit clock events, generated in master and detected in slave
  wire sckMoved = sckSync != sckPrev;
  wire leadS = sckMoved & (sckSync != ctrlOne.clockIdlePolarity);
  wire trailS = sckMoved & (sckSync == ctrlOne.clockIdlePolarity);
  wire leadM = divCnt == 10'h000;
  wire trailM = divCnt == halfRatio;
  wire slotLast = divCnt == ratio - 10'h001;
  wire leadEv = isMaster ? leadM : leadS;
  wire trailEv = isMaster ? trailM : trailS;
  wire sampleEv = inWord & (smpEff ? (ckeEff ? trailEv : slotLast) : (ckeEff ? leadEv : trailEv));
  wire changeEv = inWord & (ckeEff ? trailEv : leadEv);
  wire bitStep = isMaster ? (inWord & slotLast) : sampleEv;
  wire wordEnd = bitStep & (bitCnt == wordBits - 5'h01);
  wire [15:0] rxShift = {shiftReg[14:0], sdiSync};
  wire [15:0] rxWord = sampleEv ? rxShift : shiftReg;
  wire [15:0] rxMasked = wide ? rxWord : {8'h00, rxWord[7:0]};

  // Transfer start, abort and flag events
  wire isIdle = state == spc_pkg::IDLE;
  wire startMaster = isIdle & portEnable & isMaster & txFull & (~framed | frameMaster | syncActive);
  wire startSlave = isIdle & portEnable & ~isMaster & slaveSelected;
  wire loadTx = startMaster | startSlave;
  wire abortSlave = inWord & ~isMaster & ctrlOne.slaveSelectEnable & ~framed & selSync;
  wire ovClear = statWr & byteenable[0] & writedata[spc_pkg::ST_OVERFLOW];
  wire ovSet = wordEnd & rxFull & ~dataRd;
  wire pulseOn = frameMaster & (ctrlTwo.frameSyncEdge ? (inWord & (bitCnt == 5'h00))
    : (state == spc_pkg::PRESYNC));

  // Sequencer next state
  always_comb begin
    next_state = state;
    unique case (state)
      spc_pkg::IDLE: begin
        if (startMaster) begin
          next_state = (frameMaster & ~ctrlTwo.frameSyncEdge) ? spc_pkg::PRESYNC : spc_pkg::SHIFT;
        end else if (startSlave) begin
          next_state = spc_pkg::SHIFT;
        end
      end
      spc_pkg::PRESYNC: begin
        if (slotLast) begin
          next_state = spc_pkg::SHIFT;
        end
      end
      spc_pkg::SHIFT: begin
        if (wordEnd | abortSlave) begin
          next_state = spc_pkg::IDLE;
        end
      end
      default: begin
        next_state = spc_pkg::IDLE;
      end
    endcase
    if (!portEnable) begin
      next_state = spc_pkg::IDLE;
    end
  end

  // Bus response and read data
  always_ff @(posedge clock) begin
    if (reset) begin
      respond <= 1'b0;
      readdata <= 32'h00000000;
    end else begin
      respond <= (read | write) & ~respond;
      if (read & ~respond) begin
        readdata <= {16'h0000, readMux};
      end
    end
  end

  // Control registers and transmit buffer
  always_ff @(posedge clock) begin
    if (reset) begin
      ctrlOne <= spc_pkg::CONTROL_RESET;
      ctrlTwo <= spc_pkg::CONTROL_RESET;
      portEnable <= 1'b0;
      txBuf <= 16'h0000;
    end else begin
      if (wrAcc & hitOne) begin
        ctrlOne <= merge(16'(ctrlOne), spc_pkg::CONTROL_ONE_MASK);
      end
      if (wrAcc & hitTwo) begin
        ctrlTwo <= merge(16'(ctrlTwo), spc_pkg::CONTROL_TWO_MASK);
      end
      if (statWr & byteenable[1]) begin
        portEnable <= writedata[spc_pkg::ST_ENABLE];
      end
      if (dataWr) begin
        txBuf <= merge(txBuf, 16'hffff);
      end
    end
  end

  // Buffer flags, set wins over clear
  always_ff @(posedge clock) begin
    if (reset) begin
      txFull <= 1'b0;
      rxFull <= 1'b0;
      overflow <= 1'b0;
      rxBuf <= 16'h0000;
    end else begin
      txFull <= (txFull & ~loadTx) | dataWr;
      rxFull <= (rxFull & ~dataRd) | wordEnd;
      overflow <= (overflow & ~ovClear) | ovSet;
      if (wordEnd & ~ovSet) begin
        rxBuf <= rxMasked;
      end
    end
  end

  // Sequencer state and counters
  always_ff @(posedge clock) begin
    if (reset) begin
      state <= spc_pkg::IDLE;
      divCnt <= 10'h000;
      bitCnt <= 5'h00;
    end else begin
      state <= next_state;
      if (isMaster & ~isIdle & ~slotLast) begin
        divCnt <= divCnt + 10'h001;
      end else begin
        divCnt <= 10'h000;
      end
      if (loadTx) begin
        bitCnt <= 5'h00;
      end else if (bitStep) begin
        bitCnt <= bitCnt + 5'h01;
      end
    end
  end

  // Shift register, data out, clock and frame pulse levels
  always_ff @(posedge clock) begin
    if (reset) begin
      shiftReg <= 16'h0000;
      outBit <= 1'b0;
      sckLevel <= 1'b0;
      selLevel <= 1'b1;
      sckPrev <= 1'b0;
    end else begin
      sckPrev <= sckSync;
      selLevel <= pulseOn ? ctrlTwo.frameSyncPolarity : ~ctrlTwo.frameSyncPolarity;
      if (loadTx) begin
        shiftReg <= txBuf;
        outBit <= txBuf[topIdx];
      end else begin
        if (sampleEv) begin
          shiftReg <= rxShift;
        end
        if (changeEv) begin
          outBit <= sampleEv ? shiftReg[nextTop] : shiftReg[topIdx];
        end
      end
      if (inWord & isMaster & leadM) begin
        sckLevel <= ~ctrlOne.clockIdlePolarity;
      end else if (~inWord | trailM) begin
        sckLevel <= ctrlOne.clockIdlePolarity;
      end
    end
  end

  // Pin drive and release
  assign pinOut.clockOut = sckLevel;
  assign pinOut.clockOe = portEnable & isMaster & ~ctrlOne.clockPinDisable;
  assign pinOut.dataOut = outBit;
  assign pinOut.dataOe = portEnable & ~ctrlOne.dataOutPinDisable;
  assign pinOut.selectOut = selLevel;
  assign pinOut.selectOe = portEnable & frameMaster;

  // Checks on the block's own behaviour
  default clocking dcb @(posedge clock);
  endclocking
  default disable iff (reset);

  property p_clock_release;
    ctrlOne.clockPinDisable |-> !pinOut.clockOe;
  endproperty
  a_clock_release: assert property (p_clock_release) else $error("clock pin driven while released");

  property p_data_release;
    (portEnable && $past(ctrlOne.dataOutPinDisable) && ctrlOne.dataOutPinDisable) |-> !pinOut.dataOe;
  endproperty
  a_data_release: assert property (p_data_release) else $error("data pin driven while released");

  property p_word_length;
    wordEnd |-> (bitCnt == (wide ? 5'd15 : 5'd7));
  endproperty
  a_word_length: assert property (p_word_length) else $error("word ended at wrong bit count");

  property p_sample_end;
    (isMaster && !ckeEff && smpEff && sampleEv) |-> slotLast;
  endproperty
  a_sample_end: assert property (p_sample_end) else $error("end sample not at slot end");

  property p_change_edge;
    ($changed(outBit) && $past(inWord && isMaster && ckeEff && !loadTx)) |-> $past(trailM);
  endproperty
  a_change_edge: assert property (p_change_edge) else $error("data changed off trailing edge");

  property p_slave_abort;
    (inWord && !isMaster && ctrlOne.slaveSelectEnable && !framed && selSync) |=> isIdle;
  endproperty
  a_slave_abort: assert property (p_slave_abort) else $error("slave kept shifting while deselected");

  property p_idle_level;
    (isIdle && $past(isIdle) && $stable(ctrlOne.clockIdlePolarity)) |-> pinOut.clockOut == ctrlOne.clockIdlePolarity;
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("clock not at idle level");

  property p_slave_clock;
    !isMaster |-> !pinOut.clockOe;
  endproperty
  a_slave_clock: assert property (p_slave_clock) else $error("slave drives clock pin");

  property p_ratio_max;
    (ctrlOne.primaryDivider == 2'b00 && ctrlOne.secondaryDivider == 3'b000) |-> ratio == 10'd512;
  endproperty
  a_ratio_max: assert property (p_ratio_max) else $error("largest divide ratio wrong");

  property p_ratio_mid;
    (ctrlOne.primaryDivider == 2'b10 && ctrlOne.secondaryDivider == 3'b110) |-> ratio == 10'd8;
  endproperty
  a_ratio_mid: assert property (p_ratio_mid) else $error("mixed divide ratio wrong");

  property p_framed_edge;
    framed |-> !ckeEff;
  endproperty
  a_framed_edge: assert property (p_framed_edge) else $error("edge select used in framed mode");

  property p_frame_idle;
    (frameMaster && isIdle && $past(isIdle) && $stable(ctrlTwo)) |-> pinOut.selectOut == !ctrlTwo.frameSyncPolarity;
  endproperty
  a_frame_idle: assert property (p_frame_idle) else $error("frame pulse active outside a word");

  property p_control_two_read;
    (rdAcc && hitTwo) |-> (readdata[31:16] == 16'h0000 && readdata[12:2] == 11'h000 && readdata[0] == 1'b0);
  endproperty
  a_control_two_read: assert property (p_control_two_read) else $error("unimplemented bits read nonzero");

  property p_receive;
    (wordEnd && !rxFull) |=> (rxFull && rxBuf == $past(rxMasked));
  endproperty
  a_receive: assert property (p_receive) else $error("received word not buffered");

endmodule

/* File: hw/spc_sync.sv */
// Purpose: Three-stage input synchroniser with agreement filter
// Assumes: Input is asynchronous to clock
// Notes: Output follows only when stages two and three agree
`timescale 1ns/1ps
module spc_sync #(
  parameter logic INIT = 1'b0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Raw and filtered level
  input wire logic async,
  output logic level
);

  logic stageOne;
  logic stageTwo;
  logic stageThree;

  // Shift chain and agreement filter
  always_ff @(posedge clock) begin
    if (reset) begin
      stageOne <= INIT;
      stageTwo <= INIT;
      stageThree <= INIT;
      level <= INIT;
    end else begin
      stageOne <= async;
      stageTwo <= stageOne;
      stageThree <= stageTwo;
      if (stageTwo == stageThree) begin
        level <= stageThree;
      end
    end
  end

endmodule

/* File: sim/spc_peer.sv */
// Purpose: Far-side serial peripheral answering the port in master operation
// Assumes: Clock polarity and word size are set up before each word
// Notes: Behavioural; arm starts a word, releases the data line by inverting it
`timescale 1ns/1ps
module spc_peer (
  // Link pins
  input wire logic serialClock,
  input wire logic serialData,
  output logic dataToPort,
  // Word setup and result
  input wire logic clockPolarity,
  input wire logic [4:0] wordBits,
  input wire logic [15:0] reply,
  input wire logic arm,
  output logic [15:0] captured
);
  int bitCount = 0;
  initial dataToPort = 1'b0;
  initial captured = 16'h0000;
  // New word: clear counters, drop the held bit
  always @(posedge arm) begin
    bitCount = 0;
    captured = 16'h0000;
    dataToPort = ~dataToPort;
  end
  // Leading edge presents next bit, trailing edge captures one
  always @(serialClock) begin
    if (serialClock !== clockPolarity && bitCount < wordBits) begin
      dataToPort = reply[wordBits - 1 - bitCount];
    end else if (serialClock === clockPolarity && bitCount < wordBits) begin
      captured = {captured[14:0], serialData};
      bitCount++;
    end
  end
endmodule

/* File: sim/spc_port_test.sv */
// Purpose: Self-checking bench of the serial port registers and link
// Assumes: One wait state per bus access, peer model on the link in master role
// Notes: Bench drives the link clock itself when the port is a slave
`timescale 1ns/1ps
`define CHECK(got, exp) begin totalChecks++; if ((got) !== (exp)) begin errorCnt++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module spc_port_test;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic [31:0] rdata;
  wire logic waitrequest;
  spc_pkg::spc_pin_in_type pinIn;
  spc_pkg::spc_pin_out_type pinOut;
  logic linkClock = 1'b0;
  logic linkData = 1'b0;
  logic slaveRole = 1'b0;
  logic selectLevel = 1'b1;
  logic peerArm = 1'b0;
  logic [4:0] peerBits = 5'h08;
  logic [15:0] peerReply = 16'h0000;
  logic peerData;
  logic [15:0] peerCaptured;
  int errorCnt = 0;
  int totalChecks = 0;
  int p;
  logic [4:0] codes [6] = '{5'b11110, 5'b11011, 5'b00011, 5'b11101, 5'b11100, 5'b10110};
  int ratios [6] = '{4, 2, 8, 16, 64, 12};

  // Clock and pin wiring
  always #2 clock = ~clock;
  assign pinIn = {pinOut.clockOe ? pinOut.clockOut : linkClock, slaveRole ? linkData : peerData, selectLevel};

  spc_port u_dut (.clock(clock), .reset(reset), .address(address), .read(read), .write(write),
    .byteenable(4'h3), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .pinIn(pinIn), .pinOut(pinOut));

  spc_peer u_peer (.serialClock(pinOut.clockOut), .serialData(pinOut.dataOut), .dataToPort(peerData),
    .clockPolarity(1'b0), .wordBits(peerBits), .reply(peerReply), .arm(peerArm), .captured(peerCaptured));

  // Verdict and end of run
  task automatic finishTest();
    $display("checks=%0d errors=%0d", totalChecks, errorCnt);
    if (errorCnt == 0 && totalChecks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // One bus access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] adr, input logic [15:0] wd);
    int n;
    n = 0;
    @(posedge clock);
    address <= adr;
    read <= ~wr;
    write <= wr;
    writedata <= {16'h0000, wd};
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 100);
    rdata = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 100) begin
      errorCnt++;
      finishTest();
    end
  endtask

  // Poll status until receive buffer is full
  task automatic wait_rx();
    int n;
    n = 0;
    do begin
      bus(1'b0, spc_pkg::OFS_STATUS, 16'h0000);
      n++;
    end while (rdata[0] !== 1'b1 && n < 400);
    if (n >= 400) begin
      errorCnt++;
      finishTest();
    end
  endtask

  // Cycles between two rising edges of the serial clock
  task automatic period(output int q);
    int n;
    n = 0;
    q = 0;
    while (pinOut.clockOut !== 1'b1 && n < 2000) begin @(posedge clock); n++; end
    while (pinOut.clockOut !== 1'b0 && n < 2000) begin @(posedge clock); n++; q++; end
    while (pinOut.clockOut !== 1'b1 && n < 2000) begin @(posedge clock); n++; q++; end
  endtask

  // Bench as link master: one byte, 64 ns clock, MSB first
  task automatic link_send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      linkData <= b[i];
      linkClock <= 1'b1;
      repeat (8) @(posedge clock);
      linkClock <= 1'b0;
      repeat (8) @(posedge clock);
    end
    linkData <= ~b[0];
  endtask

  // Main sequence
  initial begin
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    bus(1'b0, spc_pkg::OFS_CONTROL_ONE, 16'h0000);
    `CHECK(rdata, 32'h0)
    bus(1'b0, spc_pkg::OFS_CONTROL_TWO, 16'h0000);
    `CHECK(rdata, 32'h0)
    bus(1'b1, spc_pkg::OFS_CONTROL_ONE, 16'hfffe);
    bus(1'b0, spc_pkg::OFS_CONTROL_ONE, 16'h0000);
    `CHECK(rdata, {16'h0, spc_pkg::CONTROL_ONE_MASK & 16'hfffe})
    bus(1'b1, spc_pkg::OFS_CONTROL_ONE, 16'h0000);
    bus(1'b1, spc_pkg::OFS_CONTROL_TWO, 16'hfffe);
    bus(1'b0, spc_pkg::OFS_CONTROL_TWO, 16'h0000);
    `CHECK(rdata, {16'h0, spc_pkg::CONTROL_TWO_MASK})
    bus(1'b0, 4'h2, 16'h0000);
    `CHECK(rdata, 32'h0)
    // Select pin ownership with the port enabled: frame master and receiver, active-high and active-low pulse
    bus(1'b1, spc_pkg::OFS_CONTROL_TWO, 16'ha000);
    bus(1'b1, spc_pkg::OFS_STATUS, 16'h8000);
    repeat (2) @(posedge clock);
    `CHECK(pinOut.selectOe, 1'b1)
    `CHECK(pinOut.selectOut, 1'b0)
    bus(1'b1, spc_pkg::OFS_CONTROL_TWO, 16'hc000);
    repeat (2) @(posedge clock);
    `CHECK(pinOut.selectOe, 1'b0)
    bus(1'b1, spc_pkg::OFS_CONTROL_TWO, 16'h8000);
    repeat (2) @(posedge clock);
    `CHECK(pinOut.selectOut, 1'b1)
    bus(1'b1, spc_pkg::OFS_CONTROL_TWO, 16'h0000);
    // Reconfigure while disabled so no stray word is running
    bus(1'b1, spc_pkg::OFS_STATUS, 16'h0000);
    bus(1'b1, spc_pkg::OFS_CONTROL_ONE, 16'h183e);
    bus(1'b1, spc_pkg::OFS_STATUS, 16'h8000);
    repeat (2) @(posedge clock);
    `CHECK({pinOut.clockOe, pinOut.dataOe}, 2'b00)
    bus(1'b1, spc_pkg::OFS_CONTROL_ONE, 16'h007e);
    repeat (2) @(posedge clock);
    `CHECK({pinOut.clockOe, pinOut.dataOe, pinOut.clockOut}, 3'b111)
    bus(1'b1, spc_pkg::OFS_CONTROL_ONE, 16'h0000);
    repeat (2) @(posedge clock);
    `CHECK(pinOut.clockOe, 1'b0)
    // Bit rate for six divider pairs, the idle slave word dropped first
    bus(1'b1, spc_pkg::OFS_STATUS, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, spc_pkg::OFS_CONTROL_ONE, {11'h001, codes[i]});
      bus(1'b1, spc_pkg::OFS_STATUS, 16'h8000);
      bus(1'b1, spc_pkg::OFS_DATA, 16'h0000);
      period(p);
      `CHECK(p, ratios[i])
      wait_rx();
      bus(1'b0, spc_pkg::OFS_DATA, 16'h0000);
    end
    // Byte and word exchange with the peer, both sample phases
    bus(1'b1, spc_pkg::OFS_CONTROL_ONE, 16'h003d);
    peerReply <= 16'h00c3;
    peerArm <= 1'b1;
    bus(1'b1, spc_pkg::OFS_DATA, 16'h12a5);
    peerArm <= 1'b0;
    wait_rx();
    bus(1'b0, spc_pkg::OFS_DATA, 16'h0000);
    `CHECK(rdata, 32'h000000c3)
    `CHECK(peerCaptured, 16'h00a5)
    bus(1'b1, spc_pkg::OFS_CONTROL_ONE, 16'h063d);
    peerBits <= 5'h10;
    peerReply <= 16'h5a96;
    peerArm <= 1'b1;
    bus(1'b1, spc_pkg::OFS_DATA, 16'hc3e1);
    peerArm <= 1'b0;
    wait_rx();
    bus(1'b0, spc_pkg::OFS_DATA, 16'h0000);
    `CHECK(rdata, 32'h00005a96)
    `CHECK(peerCaptured, 16'hc3e1)
    // Slave receive, then select pin honoured
    slaveRole <= 1'b1;
    bus(1'b1, spc_pkg::OFS_CONTROL_ONE, 16'h0000);
    repeat (8) @(posedge clock);
    link_send(8'h6b);
    wait_rx();
    bus(1'b0, spc_pkg::OFS_DATA, 16'h0000);
    `CHECK(rdata, 32'h0000006b)
    bus(1'b1, spc_pkg::OFS_CONTROL_ONE, 16'h0080);
    link_send(8'h55);
    repeat (8) @(posedge clock);
    bus(1'b0, spc_pkg::OFS_STATUS, 16'h0000);
    `CHECK(rdata[0], 1'b0)
    selectLevel <= 1'b0;
    repeat (8) @(posedge clock);
    link_send(8'h3c);
    wait_rx();
    bus(1'b0, spc_pkg::OFS_DATA, 16'h0000);
    `CHECK(rdata, 32'h0000003c)
    finishTest();
  end
endmodule
